// [src/lsac_regs.svh]
/*
  register map, field positions, reset values and constants for the line status,
  alarm and counter block. assumes a 32-bit wishbone slave, one 16-bit register
  per aligned word: byte address = word index * 4.
*/
`ifndef LSAC_REGS_SVH
`define LSAC_REGS_SVH

// ----------------------------------------------------------------------
// word indices
// ----------------------------------------------------------------------
`define LSAC_IDX_CFG_A      8'h00
`define LSAC_IDX_CFG_B      8'h01
`define LSAC_IDX_LINE_EN    8'h2d
`define LSAC_IDX_OVFL_EN    8'h2f
`define LSAC_IDX_LINE_STAT  8'h38
`define LSAC_IDX_OVFL_STAT  8'h3a
`define LSAC_IDX_CNT_BASE   8'h40

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define LSAC_CFG_A_MODE_LSB 0
`define LSAC_CFG_A_MODE_MSB 2
`define LSAC_CFG_A_SEC_LAT  13
`define LSAC_CFG_B_TXA_LSB  4
`define LSAC_CFG_B_TXA_MID  5
`define LSAC_CFG_B_TXA_MSB  6
`define LSAC_STAT_LOS       0
`define LSAC_STAT_ERR_LSB   9
`define LSAC_STAT_ERR_MSB   13
`define LSAC_STAT_SEC       14
`define LSAC_STAT_FEBE      15
`define LSAC_VIOL_CNT       2

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define LSAC_RST_REG16      16'h0000
`define LSAC_CNT_MAX        16'hffff
`define LSAC_FEBE_PEND_MAX  4'hf

`endif

// [src/lsac_pkg.sv]
/*
  types for the line status, alarm and counter block.
  assumes nothing of its surroundings.
*/
package lsac_pkg;

  // line mode held in the low bits of line_config_a
  typedef enum logic [2:0] {
    LSAC_MODE_SONET,
    LSAC_MODE_DS3,
    LSAC_MODE_G832,
    LSAC_MODE_G751,
    LSAC_MODE_EXT57,
    LSAC_MODE_PAR
  } lsac_mode_type;

endpackage : lsac_pkg

// [src/lsac_line_status.sv]
/*
  line status, interrupt, 16-bit line counters with one-second latching and
  transmit alarm controls. assumes a classic wishbone master, framer indications
  synchronous to i_clk, and a slow one-second strobe from another source.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lsac_regs.svh"

module lsac_line_status #(
  parameter int N_CNT = 4
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // wishbone slave
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [9:0]       i_wb_adr,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [31:0]      i_wb_dat,
  output logic      [31:0]      o_wb_dat,
  output logic                  o_wb_ack,
  // framer indications
  input  wire logic [15:0]      i_line_cond,
  input  wire logic [N_CNT-1:0] i_cnt_evt,
  input  wire logic             i_rx_violation_flag,
  input  wire logic             i_one_second_strobe_in,
  input  wire logic             i_rx_febe_err,
  input  wire logic             i_tx_mframe_start,
  // interrupt and transmit alarm controls
  output logic                  o_stat_int,
  output logic                  o_tx_ds3_ais,
  output logic                  o_tx_ds3_idle,
  output logic                  o_tx_ds3_xbit_yellow,
  output logic                  o_tx_ds3_febe_zero,
  output logic                  o_tx_e3_ais,
  output logic                  o_tx_e3_abit,
  output logic                  o_tx_g832_ais,
  output logic                  o_tx_g832_ferf,
  output logic                  o_tx_g832_tmark
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : wr16

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0] cfg_a_reg, cfg_a_next, cfg_b_reg, cfg_b_next;
  logic [15:0] line_en_reg, line_en_next, ovfl_en_reg, ovfl_en_next;
  logic [15:0] stat_reg, stat_next, ovfl_reg, ovfl_next, cond_reg;
  logic [15:0] live_reg [N_CNT], live_next [N_CNT];
  logic [15:0] lat_reg [N_CNT], lat_next [N_CNT];
  logic [31:0] dat_next;
  logic        ack_next, int_next;
  logic        sec_s1_reg, sec_s2_reg, sec_s3_reg;
  logic [3:0]  febe_pend_reg, febe_pend_next;
  logic        febe_zero_reg, febe_zero_next;
  logic [6:0]  txa_next;
  logic [6:0]  txa_reg;
  logic        tmark_reg, tmark_next;

  lsac_pkg::lsac_mode_type mode;
  logic        sec_edge, acc, rd_fire, wr_fire, lat_en;
  logic [7:0]  idx;
  logic [15:0] stat_evt;

  assign mode     = lsac_pkg::lsac_mode_type'(cfg_a_reg[`LSAC_CFG_A_MODE_MSB:`LSAC_CFG_A_MODE_LSB]);
  assign idx      = i_wb_adr[9:2];
  assign acc      = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign rd_fire  = acc && !i_wb_we;
  assign wr_fire  = acc && i_wb_we;
  assign lat_en   = cfg_a_reg[`LSAC_CFG_A_SEC_LAT];
  // the second and third flops of the synchroniser feed the edge detector
  assign sec_edge = sec_s2_reg && !sec_s3_reg;

  // ----------------------------------------------------------------------
  // status events
  // ----------------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      if (b >= `LSAC_STAT_ERR_LSB && b <= `LSAC_STAT_ERR_MSB) begin
        stat_evt[b] = i_line_cond[b];
      end else begin
        stat_evt[b] = i_line_cond[b] ^ cond_reg[b];
      end
    end
    stat_evt[`LSAC_STAT_SEC]  = sec_edge;
    stat_evt[`LSAC_STAT_FEBE] = (mode == lsac_pkg::LSAC_MODE_SONET) && i_line_cond[`LSAC_STAT_FEBE];
  end

  // ----------------------------------------------------------------------
  // register file, status and counters
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] base;
    logic        evt;
    logic        rd_cnt;
    base = 16'h0000;
    evt  = 1'b0;
    rd_cnt = 1'b0;
    cfg_a_next   = cfg_a_reg;
    cfg_b_next   = cfg_b_reg;
    line_en_next = line_en_reg;
    ovfl_en_next = ovfl_en_reg;
    stat_next    = stat_reg;
    ovfl_next    = ovfl_reg;
    ack_next     = acc;
    dat_next     = 32'h0000_0000;
    if (wr_fire) begin
      if (idx == `LSAC_IDX_CFG_A) begin
        cfg_a_next = wr16(cfg_a_reg, i_wb_dat, i_wb_sel);
      end else if (idx == `LSAC_IDX_CFG_B) begin
        cfg_b_next = wr16(cfg_b_reg, i_wb_dat, i_wb_sel);
      end else if (idx == `LSAC_IDX_LINE_EN) begin
        line_en_next = wr16(line_en_reg, i_wb_dat, i_wb_sel);
      end else if (idx == `LSAC_IDX_OVFL_EN) begin
        ovfl_en_next = wr16(ovfl_en_reg, i_wb_dat, i_wb_sel);
      end
    end
    if (rd_fire) begin
      if (idx == `LSAC_IDX_CFG_A) begin
        dat_next[15:0] = cfg_a_reg;
      end else if (idx == `LSAC_IDX_CFG_B) begin
        dat_next[15:0] = cfg_b_reg;
      end else if (idx == `LSAC_IDX_LINE_EN) begin
        dat_next[15:0] = line_en_reg;
      end else if (idx == `LSAC_IDX_OVFL_EN) begin
        dat_next[15:0] = ovfl_en_reg;
      end else if (idx == `LSAC_IDX_LINE_STAT) begin
        dat_next[15:0] = stat_reg;
        stat_next      = 16'h0000;
      end else if (idx == `LSAC_IDX_OVFL_STAT) begin
        dat_next[15:0] = ovfl_reg;
        ovfl_next      = 16'h0000;
      end
    end
    // new events override the read clear so none is lost
    stat_next = stat_next | stat_evt;
    for (int k = 0; k < N_CNT; k++) begin
      rd_cnt = rd_fire && (idx == `LSAC_IDX_CNT_BASE + 8'(k));
      evt    = (k == `LSAC_VIOL_CNT && mode == lsac_pkg::LSAC_MODE_PAR) ? i_rx_violation_flag : i_cnt_evt[k];
      lat_next[k] = lat_reg[k];
      base        = live_reg[k];
      if (k == 0 || lat_en) begin
        if (rd_cnt) begin
          dat_next[15:0] = lat_reg[k];
          if (k == 0) begin
            lat_next[k] = 16'h0000;
          end
        end
      end else if (rd_cnt) begin
        dat_next[15:0] = live_reg[k];
        base           = 16'h0000;
      end
      if (sec_edge && (k == 0 || lat_en)) begin
        lat_next[k] = live_reg[k];
        base        = 16'h0000;
      end
      live_next[k] = base;
      if (evt) begin
        if (base != `LSAC_CNT_MAX) begin
          live_next[k] = base + 16'h0001;
        end else if (ovfl_en_reg[k]) begin
          live_next[k] = 16'h0000;
          ovfl_next[k] = 1'b1;
        end
      end
    end
    int_next = |(stat_next & line_en_next) || |(ovfl_next & ovfl_en_next);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_a_reg   <= `LSAC_RST_REG16;
      cfg_b_reg   <= `LSAC_RST_REG16;
      line_en_reg <= `LSAC_RST_REG16;
      ovfl_en_reg <= `LSAC_RST_REG16;
      stat_reg    <= `LSAC_RST_REG16;
      ovfl_reg    <= `LSAC_RST_REG16;
      cond_reg    <= `LSAC_RST_REG16;
      o_wb_ack    <= 1'b0;
      o_wb_dat    <= 32'h0000_0000;
      o_stat_int  <= 1'b0;
      sec_s1_reg  <= 1'b0;
      sec_s2_reg  <= 1'b0;
      sec_s3_reg  <= 1'b0;
      for (int k = 0; k < N_CNT; k++) begin
        live_reg[k] <= `LSAC_RST_REG16;
        lat_reg[k]  <= `LSAC_RST_REG16;
      end
    end else begin
      cfg_a_reg   <= cfg_a_next;
      cfg_b_reg   <= cfg_b_next;
      line_en_reg <= line_en_next;
      ovfl_en_reg <= ovfl_en_next;
      stat_reg    <= stat_next;
      ovfl_reg    <= ovfl_next;
      cond_reg    <= i_line_cond;
      o_wb_ack    <= ack_next;
      o_wb_dat    <= dat_next;
      o_stat_int  <= int_next;
      sec_s1_reg  <= i_one_second_strobe_in;
      sec_s2_reg  <= sec_s1_reg;
      sec_s3_reg  <= sec_s2_reg;
      for (int k = 0; k < N_CNT; k++) begin
        live_reg[k] <= live_next[k];
        lat_reg[k]  <= lat_next[k];
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmit alarms and ds3 febe
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] a;
    a = cfg_b_reg[`LSAC_CFG_B_TXA_MSB:`LSAC_CFG_B_TXA_LSB];
    txa_next = 7'h00;
    if (mode == lsac_pkg::LSAC_MODE_DS3) begin
      txa_next[0] = a[0];
      txa_next[1] = !a[0] && a[1];
      txa_next[2] = !a[0] && !a[1] && a[2];
    end else if (mode == lsac_pkg::LSAC_MODE_G751) begin
      txa_next[3] = a[0];
      txa_next[4] = a[2];
    end else if (mode == lsac_pkg::LSAC_MODE_G832) begin
      txa_next[5] = a[0];
      txa_next[6] = a[1];
    end
    tmark_next = (mode == lsac_pkg::LSAC_MODE_G832) && a[2];
    febe_pend_next = febe_pend_reg;
    febe_zero_next = febe_zero_reg;
    // one zero m-frame is owed per error; the backlog saturates rather than wraps
    if (i_tx_mframe_start) begin
      febe_zero_next = (febe_pend_reg != 4'h0);
      if (febe_pend_reg != 4'h0) begin
        febe_pend_next = febe_pend_reg - 4'h1;
      end
    end
    if (i_rx_febe_err && febe_pend_next != `LSAC_FEBE_PEND_MAX) begin
      febe_pend_next = febe_pend_next + 4'h1;
    end
    if (mode != lsac_pkg::LSAC_MODE_DS3) begin
      febe_pend_next = 4'h0;
      febe_zero_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      txa_reg       <= 7'h00;
      febe_pend_reg <= 4'h0;
      febe_zero_reg <= 1'b0;
      tmark_reg     <= 1'b0;
    end else begin
      txa_reg       <= txa_next;
      febe_pend_reg <= febe_pend_next;
      febe_zero_reg <= febe_zero_next;
      tmark_reg     <= tmark_next;
    end
  end

  assign o_tx_ds3_ais         = txa_reg[0];
  assign o_tx_ds3_idle        = txa_reg[1];
  assign o_tx_ds3_xbit_yellow = txa_reg[2];
  assign o_tx_e3_ais          = txa_reg[3];
  assign o_tx_e3_abit         = txa_reg[4];
  assign o_tx_g832_ais        = txa_reg[5];
  assign o_tx_g832_ferf       = txa_reg[6];
  assign o_tx_g832_tmark      = tmark_reg;
  assign o_tx_ds3_febe_zero   = febe_zero_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_int_on_pending;
    @(posedge i_clk) disable iff (!i_arst_n) (|(stat_reg & line_en_reg) && !rd_fire && !wr_fire) |=> o_stat_int;
  endproperty
  a_int_on_pending: assert property (p_int_on_pending) else $error("pending enabled status without interrupt");

  property p_read_clears;
    @(posedge i_clk) disable iff (!i_arst_n)
      (rd_fire && idx == `LSAC_IDX_LINE_STAT && stat_evt == 16'h0000) |=> (stat_reg == 16'h0000);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

  property p_err_sets;
    @(posedge i_clk) disable iff (!i_arst_n) i_line_cond[`LSAC_STAT_ERR_LSB] |=> stat_reg[`LSAC_STAT_ERR_LSB];
  endproperty
  a_err_sets: assert property (p_err_sets) else $error("error occurrence lost");

  property p_alarm_change;
    @(posedge i_clk) disable iff (!i_arst_n) (i_line_cond[`LSAC_STAT_LOS] != cond_reg[`LSAC_STAT_LOS]) |=> stat_reg[`LSAC_STAT_LOS];
  endproperty
  a_alarm_change: assert property (p_alarm_change) else $error("alarm change lost");

  property p_wrap;
    @(posedge i_clk) disable iff (!i_arst_n)
      (live_reg[1] == `LSAC_CNT_MAX && ovfl_en_reg[1] && i_cnt_evt[1] && !sec_edge && !rd_fire)
      |=> (live_reg[1] == 16'h0000 && ovfl_reg[1]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap with overflow");

  property p_saturate;
    @(posedge i_clk) disable iff (!i_arst_n)
      (live_reg[N_CNT-1] == `LSAC_CNT_MAX && !ovfl_en_reg[N_CNT-1] && !sec_edge && !rd_fire)
      |=> (live_reg[N_CNT-1] == `LSAC_CNT_MAX);
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter left saturation");

  property p_viol_latch;
    @(posedge i_clk) disable iff (!i_arst_n) sec_edge |=> (lat_reg[0] == $past(live_reg[0]));
  endproperty
  a_viol_latch: assert property (p_viol_latch) else $error("violation count not latched");

  property p_ds3_prio;
    @(posedge i_clk) disable iff (!i_arst_n)
      (mode == lsac_pkg::LSAC_MODE_DS3 && cfg_b_reg[`LSAC_CFG_B_TXA_LSB]) ##1 $stable(cfg_b_reg)
      |-> (o_tx_ds3_ais && !o_tx_ds3_idle && !o_tx_ds3_xbit_yellow);
  endproperty
  a_ds3_prio: assert property (p_ds3_prio) else $error("ds3 alarm priority wrong");

  property p_sec_once;
    @(posedge i_clk) disable iff (!i_arst_n)
      sec_edge |-> ($past(i_one_second_strobe_in, 2) && !$past(i_one_second_strobe_in, 3));
  endproperty
  a_sec_once: assert property (p_sec_once) else $error("second strobe edge without one input rise");

  property p_viol_read_zero;
    @(posedge i_clk) disable iff (!i_arst_n)
      (rd_fire && idx == `LSAC_IDX_CNT_BASE && !sec_edge) |=> (lat_reg[0] == 16'h0000);
  endproperty
  a_viol_read_zero: assert property (p_viol_read_zero) else $error("violation count not cleared by read");

  property p_febe_zero;
    @(posedge i_clk) disable iff (!i_arst_n)
      (mode == lsac_pkg::LSAC_MODE_DS3 && i_tx_mframe_start && febe_pend_reg != 4'h0) |=> o_tx_ds3_febe_zero;
  endproperty
  a_febe_zero: assert property (p_febe_zero) else $error("owed febe zero frame not sent");

  c_status_irq: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_stat_int));
  c_wrap: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(ovfl_reg[1]));
  c_latch: cover property (@(posedge i_clk) disable iff (!i_arst_n) sec_edge && lat_en);
  c_febe_zero: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_tx_ds3_febe_zero));
  c_par_viol: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    mode == lsac_pkg::LSAC_MODE_PAR && i_rx_violation_flag);

endmodule : lsac_line_status
`default_nettype wire

// [bench/tb_lsac_line_status.sv]
/*
  self-checking bench for the line status, alarm and counter block: status
  interrupts, line counters, one-second latching and transmit alarm controls.
  assumes lsac_pkg, lsac_regs.svh and lsac_line_status are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lsac_regs.svh"

module tb_lsac_line_status;
  // ----------------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------------
  logic        i_clk;
  logic        i_arst_n;
  logic        i_wb_cyc;
  logic        i_wb_stb;
  logic        i_wb_we;
  logic [9:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic [15:0] i_line_cond;
  logic [3:0]  i_cnt_evt;
  logic        i_rx_violation_flag;
  logic        i_one_second_strobe_in;
  logic        i_rx_febe_err;
  logic        i_tx_mframe_start;
  logic        o_stat_int;
  logic        o_febe0;
  logic [7:0]  tx_alm;
  logic [15:0] lvl;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  int          num_errors;
  int          n_checks;
  int          n;
  lsac_pkg::lsac_mode_type modes[3] = '{lsac_pkg::LSAC_MODE_DS3, lsac_pkg::LSAC_MODE_G751, lsac_pkg::LSAC_MODE_G832};

  lsac_line_status #(.N_CNT(4)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_line_cond(i_line_cond), .i_cnt_evt(i_cnt_evt), .i_rx_violation_flag(i_rx_violation_flag),
    .i_one_second_strobe_in(i_one_second_strobe_in), .i_rx_febe_err(i_rx_febe_err),
    .i_tx_mframe_start(i_tx_mframe_start), .o_stat_int(o_stat_int), .o_tx_ds3_ais(tx_alm[7]),
    .o_tx_ds3_idle(tx_alm[6]), .o_tx_ds3_xbit_yellow(tx_alm[5]), .o_tx_ds3_febe_zero(o_febe0),
    .o_tx_e3_ais(tx_alm[4]), .o_tx_e3_abit(tx_alm[3]), .o_tx_g832_ais(tx_alm[2]),
    .o_tx_g832_ferf(tx_alm[1]), .o_tx_g832_tmark(tx_alm[0]));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic tk(input int c);
    repeat (c) @(posedge i_clk);
  endtask : tk

  // one classic cycle; reads leave their expectation for the monitor
  task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] d, input logic [15:0] e,
                    input logic [15:0] m);
    int k;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= {idx, 2'b00};
    i_wb_dat <= {16'h0000, d};
    if (!we) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      end_sim();
    end
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] idx, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    wb(1'b0, idx, 16'h0000, e, m);
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    wb(1'b1, idx, d, 16'h0000, 16'h0000);
  endtask : wr

  // hold indications for cyc cycles, then fall back to the alarm levels in lvl
  task automatic drv(input logic [15:0] c, input logic [3:0] ev, input logic v, input int cyc);
    repeat (cyc) begin
      @(posedge i_clk);
      i_line_cond         <= c | lvl;
      i_cnt_evt           <= ev;
      i_rx_violation_flag <= v;
    end
    @(posedge i_clk);
    i_line_cond         <= lvl;
    i_cnt_evt           <= 4'h0;
    i_rx_violation_flag <= 1'b0;
  endtask : drv

  function automatic logic [7:0] exp_tx(input lsac_pkg::lsac_mode_type md, input logic [2:0] t);
    case (md)
      lsac_pkg::LSAC_MODE_DS3:  exp_tx = {t[0], t[1] & ~t[0], t[2] & ~t[1] & ~t[0], 5'h00};
      lsac_pkg::LSAC_MODE_G751: exp_tx = {3'h0, t[0], t[2], 3'h0};
      lsac_pkg::LSAC_MODE_G832: exp_tx = {5'h00, t[0], t[1], t[2]};
      default:                  exp_tx = 8'h00;
    endcase
  endfunction : exp_tx

  // ----------------------------------------------------------------------
  // read monitor: every acked read is matched with the oldest expectation
  // ----------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (o_wb_ack === 1'b1 && i_wb_cyc === 1'b1 && i_wb_we === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("read queue", 32'h1, 32'h0);
      end else begin
        chk($sformatf("read at %h", i_wb_adr), o_wb_dat & {16'hffff, msk_q[0]}, {16'h0000, exp_q[0] & msk_q[0]});
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {i_arst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_line_cond, i_cnt_evt} = '0;
    {i_rx_violation_flag, i_one_second_strobe_in, i_rx_febe_err, i_tx_mframe_start} = '0;
    i_wb_sel   = 4'h3;
    lvl        = 16'h0000;
    num_errors = 0;
    n_checks   = 0;
    void'($urandom(79));
    tk(6);
    i_arst_n <= 1'b1;
    rd(`LSAC_IDX_CFG_A, 16'h0000);
    rd(`LSAC_IDX_LINE_STAT, 16'h0000);
    rd(8'h10, 16'h0000);
    n = $urandom;
    wr(`LSAC_IDX_LINE_EN, n[15:0]);
    rd(`LSAC_IDX_LINE_EN, n[15:0]);
    wr(`LSAC_IDX_OVFL_STAT, 16'hffff);
    rd(`LSAC_IDX_OVFL_STAT, 16'h0000);
    $display("test registers done");

    wr(`LSAC_IDX_LINE_EN, 16'h0204);
    drv(16'h0200, 4'h0, 1'b0, 1);
    tk(2);
    chk("stat_int error", o_stat_int, 32'h1);
    rd(`LSAC_IDX_LINE_STAT, 16'h0200);
    tk(2);
    chk("stat_int after read", o_stat_int, 32'h0);
    drv(16'h0400, 4'h0, 1'b0, 1);
    tk(2);
    chk("stat_int masked", o_stat_int, 32'h0);
    rd(`LSAC_IDX_LINE_STAT, 16'h0400);
    // loss of signal rises together with an enabled alarm
    lvl = 16'h0005;
    drv(16'h0000, 4'h0, 1'b0, 0);
    tk(2);
    chk("stat_int alarm rise", o_stat_int, 32'h1);
    rd(`LSAC_IDX_LINE_STAT, 16'h0005);
    rd(`LSAC_IDX_LINE_STAT, 16'h0000);
    lvl = 16'h0000;
    drv(16'h0000, 4'h0, 1'b0, 0);
    tk(2);
    chk("stat_int alarm fall", o_stat_int, 32'h1);
    rd(`LSAC_IDX_LINE_STAT, 16'h0005);
    $display("test status done");

    // counter 1 may wrap, counter 3 must saturate
    wr(`LSAC_IDX_OVFL_EN, 16'h0002);
    drv(16'h0000, 4'b1010, 1'b0, 65537);
    tk(2);
    chk("stat_int overflow", o_stat_int, 32'h1);
    rd(8'h41, 16'h0001);
    rd(8'h43, 16'hffff);
    rd(`LSAC_IDX_OVFL_STAT, 16'h0002, 16'h0002);
    tk(2);
    chk("stat_int overflow read", o_stat_int, 32'h0);
    rd(8'h43, 16'h0000);
    $display("test overflow done");

    for (int l = 0; l < 2; l++) begin
      n = 1 + ($urandom % 20);
      wr(`LSAC_IDX_CFG_A, (l == 1) ? 16'h2000 : 16'h0000);
      drv(16'h0000, 4'b0101, 1'b0, n);
      @(posedge i_clk);
      i_one_second_strobe_in <= 1'b1;
      tk(6);
      drv(16'h0000, 4'b0101, 1'b0, 3);
      tk(6);
      rd(8'h42, (l == 1) ? n[15:0] : n[15:0] + 16'h0003);
      rd(8'h42, (l == 1) ? n[15:0] : 16'h0000);
      rd(`LSAC_IDX_CNT_BASE, n[15:0]);
      rd(`LSAC_IDX_CNT_BASE, 16'h0000);
      rd(`LSAC_IDX_LINE_STAT, 16'h4000, 16'h4000);
      @(posedge i_clk);
      i_one_second_strobe_in <= 1'b0;
      tk(4);
      i_one_second_strobe_in <= 1'b1;
      tk(6);
      rd(`LSAC_IDX_CNT_BASE, 16'h0003);
      rd(8'h42, (l == 1) ? 16'h0003 : 16'h0000);
      i_one_second_strobe_in <= 1'b0;
    end
    $display("test latching done");

    wr(`LSAC_IDX_CFG_A, {13'h0000, lsac_pkg::LSAC_MODE_PAR});
    // only the one-second status bit is trusted here; the last strobe left it pending
    rd(`LSAC_IDX_LINE_STAT, 16'h4000, 16'h4000);
    rd(8'h42, 16'h0000, 16'h0000);
    drv(16'h0000, 4'h0, 1'b1, 4);
    rd(8'h42, 16'h0004);
    $display("test parallel mode done");

    for (int md = 0; md < 3; md++) begin
      wr(`LSAC_IDX_CFG_A, {13'h0000, modes[md]});
      for (int t = 0; t < 8; t++) begin
        wr(`LSAC_IDX_CFG_B, {9'h000, t[2:0], 4'h0});
        tk(2);
        chk($sformatf("tx alarm mode %0d sel %0d", md, t), tx_alm, exp_tx(modes[md], t[2:0]));
      end
    end
    $display("test transmit alarms done");

    // two receive errors give two all-zero m-frames, then all ones again
    wr(`LSAC_IDX_CFG_A, {13'h0000, lsac_pkg::LSAC_MODE_DS3});
    @(posedge i_clk);
    i_rx_febe_err <= 1'b1;
    @(posedge i_clk);
    @(posedge i_clk);
    i_rx_febe_err <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      i_tx_mframe_start <= 1'b1;
      @(posedge i_clk);
      i_tx_mframe_start <= 1'b0;
      tk(3);
      chk("febe zero", o_febe0, (i < 2) ? 32'h1 : 32'h0);
    end
    $display("test febe done");
    end_sim();
  end
endmodule : tb_lsac_line_status
`default_nettype wire
